// *** logic/tlbt_pkg.sv ***
// Constants, register map and types of the translation buffer test port
package tlbt_pkg;

   // -------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------
   localparam logic [31:0] OFF_CMD = 32'h0000_0000;
   localparam logic [31:0] OFF_DATA = 32'h0000_0004;
   localparam logic [31:0] OFF_PDB = 32'h0000_0008;

   // -------------------------------------------------------------
   // Command register fields
   // -------------------------------------------------------------
   localparam int CMD_OP = 0;
   localparam int CMD_WRT_N = 5;
   localparam int CMD_WRT = 6;
   localparam int CMD_USER_N = 7;
   localparam int CMD_USER = 8;
   localparam int CMD_DIRTY_N = 9;
   localparam int CMD_DIRTY = 10;
   localparam int CMD_VALID = 11;
   localparam int CMD_SET_LO = 12;
   localparam int CMD_TAG_LO = 15;
   localparam logic [31:0] CMD_MASK = 32'hFFFF_FFE1;
   localparam logic OP_WRITE = 1'b0;
   localparam logic OP_LOOKUP = 1'b1;

   // -------------------------------------------------------------
   // Data register fields
   // -------------------------------------------------------------
   localparam int DATA_CHOICE_LO = 2;
   localparam int DATA_HIT = 4;
   localparam int DATA_PA_LO = 12;
   localparam logic [31:0] DATA_MASK = 32'hFFFF_F01C;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [31:0] CMD_RESET = 32'h0000_0000;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
   localparam logic [31:0] PDB_RESET = 32'h0000_0000;

   // -------------------------------------------------------------
   // Buffer geometry
   // -------------------------------------------------------------
   localparam int NWAYS = 4;
   localparam int WAY_W = 2;
   localparam int NSETS = 8;
   localparam int SET_W = 3;
   localparam int TAG_W = 17;
   localparam int PA_W = 20;
   localparam int ENTRY_W = TAG_W + 3 + PA_W;

   typedef struct packed {
      logic [TAG_W-1:0] tag;
      logic dirty;
      logic user;
      logic wrt;
      logic [PA_W-1:0] pa;
   } tlbt_entry_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WRITE = 2'b01,
      ST_READ = 2'b10,
      ST_CMP = 2'b11
   } tlbt_state_t;

endpackage

// *** logic/tlbt_match.sv ***
// Tag and attribute comparator for one associative block
`timescale 1ns/100ps
module tlbt_match (
   // Clock and reset for checks
   input wire logic clock,
   input wire logic rst,
   // Stored entry
   input wire logic [tlbt_pkg::ENTRY_W-1:0] entry,
   input wire logic valid,
   // Lookup key
   input wire logic [tlbt_pkg::TAG_W-1:0] tag,
   input wire logic [1:0] dirty_pair,
   input wire logic [1:0] user_pair,
   input wire logic [1:0] wrt_pair,
   // Result
   output logic hit
);

   tlbt_pkg::tlbt_entry_t e;
   logic d_ok;
   logic u_ok;
   logic w_ok;

   // -------------------------------------------------------------
   // Pair qualifies attribute: value bit or complement bit
   // -------------------------------------------------------------
   always_comb begin
      e = tlbt_pkg::tlbt_entry_t'(entry);
      d_ok = (dirty_pair[1] & e.dirty) | (dirty_pair[0] & ~e.dirty);
      u_ok = (user_pair[1] & e.user) | (user_pair[0] & ~e.user);
      w_ok = (wrt_pair[1] & e.wrt) | (wrt_pair[0] & ~e.wrt);
      hit = valid & (e.tag == tag) & d_ok & u_ok & w_ok;
   end

   a_pair_miss_all: assert property (
      @(posedge clock) disable iff (rst)
      (dirty_pair == 2'b00 || user_pair == 2'b00 || wrt_pair == 2'b00)
         |-> !hit)
      else $error("zero attribute pair did not force a miss");

   a_pair_match_all: assert property (
      @(posedge clock) disable iff (rst)
      (valid && e.tag == tag && dirty_pair == 2'b11
         && user_pair == 2'b11 && wrt_pair == 2'b11) |-> hit)
      else $error("don't care pairs did not match valid entry");

endmodule

// *** logic/tlbt_mem.sv ***
// Storage of buffer entries with valid bits and registered read
`timescale 1ns/100ps
module tlbt_mem (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Write port
   input wire logic wr_en,
   input wire logic [tlbt_pkg::WAY_W-1:0] wr_way,
   input wire logic [tlbt_pkg::SET_W-1:0] wr_set,
   input wire logic [tlbt_pkg::ENTRY_W-1:0] wr_entry,
   // Invalidate all
   input wire logic flush,
   // Read port, all blocks of one set
   input wire logic rd_en,
   input wire logic [tlbt_pkg::SET_W-1:0] rd_set,
   output logic [tlbt_pkg::NWAYS*tlbt_pkg::ENTRY_W-1:0] rd_entries,
   output logic [tlbt_pkg::NWAYS-1:0] rd_valid
);

   localparam int NW = tlbt_pkg::NWAYS;
   localparam int EW = tlbt_pkg::ENTRY_W;
   localparam int WW = tlbt_pkg::WAY_W;
   localparam int N = tlbt_pkg::NWAYS * tlbt_pkg::NSETS;

   typedef struct packed {
      logic [N-1:0][EW-1:0] data;
      logic [N-1:0] valid;
      logic [NW*EW-1:0] rd_entries;
      logic [NW-1:0] rd_valid;
   } tlbt_mem_state_t;

   tlbt_mem_state_t r;
   tlbt_mem_state_t n;

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      logic [WW-1:0] wsel;
      wsel = '0;
      n = r;
      if (wr_en) begin
         n.data[{wr_way, wr_set}] = wr_entry;
         n.valid[{wr_way, wr_set}] = 1'b1;
      end
      if (flush) begin
         n.valid = '0;
      end
      if (rd_en) begin
         for (int w = 0; w < NW; w++) begin
            wsel = WW'(w);
            n.rd_entries[w*EW +: EW] = r.data[{wsel, rd_set}];
            n.rd_valid[w] = r.valid[{wsel, rd_set}];
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign rd_entries = r.rd_entries;
   assign rd_valid = r.rd_valid;

   a_flush_clears: assert property (
      @(posedge clock) disable iff (rst)
      flush |=> (r.valid == '0))
      else $error("valid bits survived a flush");

endmodule

// *** logic/tlbt_top.sv ***
// Translation buffer test port: APB registers, entry write and lookup
`timescale 1ns/100ps
module tlbt_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   localparam int NW = tlbt_pkg::NWAYS;
   localparam int EW = tlbt_pkg::ENTRY_W;
   localparam int WW = tlbt_pkg::WAY_W;
   localparam int SW = tlbt_pkg::SET_W;
   localparam int TW = tlbt_pkg::TAG_W;
   localparam int PW = tlbt_pkg::PA_W;

   typedef struct packed {
      logic [31:0] cmd;
      logic [31:0] data;
      logic [31:0] pdb;
      logic [WW-1:0] repl;
      tlbt_pkg::tlbt_state_t st;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } tlbt_top_state_t;

   tlbt_top_state_t r;
   tlbt_top_state_t n;

   logic mem_wr;
   logic [WW-1:0] mem_way;
   tlbt_pkg::tlbt_entry_t mem_entry;
   logic mem_flush;
   logic mem_rd;
   logic [NW*EW-1:0] rd_entries;
   logic [NW-1:0] rd_valid;
   logic [NW-1:0] hits;
   logic one_hit;
   logic [WW-1:0] hit_way;
   tlbt_pkg::tlbt_entry_t hit_entry;
   logic acc;
   logic done;
   logic sel_cmd;
   logic sel_data;
   logic sel_pdb;

   // -------------------------------------------------------------
   // Command and data register views
   // -------------------------------------------------------------
   logic [SW-1:0] cmd_set;
   logic [TW-1:0] cmd_tag;
   logic [1:0] dirty_pair;
   logic [1:0] user_pair;
   logic [1:0] wrt_pair;
   logic [PW-1:0] data_pa;
   logic [WW-1:0] data_choice;
   logic data_hit;

   assign cmd_set = r.cmd[tlbt_pkg::CMD_SET_LO +: SW];
   assign cmd_tag = r.cmd[tlbt_pkg::CMD_TAG_LO +: TW];
   assign dirty_pair = {r.cmd[tlbt_pkg::CMD_DIRTY],
                        r.cmd[tlbt_pkg::CMD_DIRTY_N]};
   assign user_pair = {r.cmd[tlbt_pkg::CMD_USER],
                       r.cmd[tlbt_pkg::CMD_USER_N]};
   assign wrt_pair = {r.cmd[tlbt_pkg::CMD_WRT],
                      r.cmd[tlbt_pkg::CMD_WRT_N]};
   assign data_pa = r.data[tlbt_pkg::DATA_PA_LO +: PW];
   assign data_choice = r.data[tlbt_pkg::DATA_CHOICE_LO +: WW];
   assign data_hit = r.data[tlbt_pkg::DATA_HIT];

   // -------------------------------------------------------------
   // Entry storage
   // -------------------------------------------------------------
   tlbt_mem u_mem (
      .clock(clock),
      .rst(rst),
      .wr_en(mem_wr),
      .wr_way(mem_way),
      .wr_set(cmd_set),
      .wr_entry(mem_entry),
      .flush(mem_flush),
      .rd_en(mem_rd),
      .rd_set(cmd_set),
      .rd_entries(rd_entries),
      .rd_valid(rd_valid)
   );

   // -------------------------------------------------------------
   // One comparator per associative block
   // -------------------------------------------------------------
   for (genvar g = 0; g < NW; g++) begin : g_match
      tlbt_match u_match (
         .clock(clock),
         .rst(rst),
         .entry(rd_entries[g*EW +: EW]),
         .valid(rd_valid[g]),
         .tag(cmd_tag),
         .dirty_pair(dirty_pair),
         .user_pair(user_pair),
         .wrt_pair(wrt_pair),
         .hit(hits[g])
      );
   end

   always_comb begin
      hit_way = '0;
      for (int i = 0; i < NW; i++) begin
         if (hits[i]) begin
            hit_way = WW'(i);
         end
      end
      hit_entry = tlbt_pkg::tlbt_entry_t'(rd_entries[hit_way*EW +: EW]);
      one_hit = $onehot(hits);
   end

   // -------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------
   assign acc = psel & penable;
   assign done = acc & r.pready;
   assign sel_cmd = (paddr == tlbt_pkg::OFF_CMD);
   assign sel_data = (paddr == tlbt_pkg::OFF_DATA);
   assign sel_pdb = (paddr == tlbt_pkg::OFF_PDB);

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      n = r;
      mem_wr = 1'b0;
      mem_way = r.repl;
      mem_flush = 1'b0;
      mem_rd = 1'b0;
      mem_entry.tag = cmd_tag;
      mem_entry.dirty = r.cmd[tlbt_pkg::CMD_DIRTY];
      mem_entry.user = r.cmd[tlbt_pkg::CMD_USER];
      mem_entry.wrt = r.cmd[tlbt_pkg::CMD_WRT];
      mem_entry.pa = data_pa;

      // Wait state, answer only while the engine is idle
      if (acc && !r.pready && r.st == tlbt_pkg::ST_IDLE) begin
         n.pready = 1'b1;
         n.pslverr = !(sel_cmd || sel_data || sel_pdb);
         n.prdata = '0;
         if (!pwrite) begin
            if (sel_cmd) begin
               n.prdata = r.cmd;
            end else if (sel_data) begin
               n.prdata = r.data;
            end else if (sel_pdb) begin
               n.prdata = r.pdb;
            end
         end
      end

      // Completion edge: writes take effect here
      if (done) begin
         n.pready = 1'b0;
         n.pslverr = 1'b0;
         if (pwrite && sel_cmd) begin
            n.cmd = pwdata & tlbt_pkg::CMD_MASK;
            if (pwdata[tlbt_pkg::CMD_OP] == tlbt_pkg::OP_LOOKUP) begin
               n.st = tlbt_pkg::ST_READ;
            end else begin
               n.st = tlbt_pkg::ST_WRITE;
            end
         end
         if (pwrite && sel_data) begin
            n.data = pwdata & tlbt_pkg::DATA_MASK;
         end
         if (pwrite && sel_pdb) begin
            n.pdb = pwdata;
            mem_flush = 1'b1;
         end
      end

      // Entry write and lookup engine
      case (r.st)
         tlbt_pkg::ST_IDLE: begin
         end
         tlbt_pkg::ST_WRITE: begin
            mem_wr = 1'b1;
            if (data_hit) begin
               mem_way = data_choice;
            end else begin
               n.repl = r.repl + WW'(1);
            end
            n.st = tlbt_pkg::ST_IDLE;
         end
         tlbt_pkg::ST_READ: begin
            mem_rd = 1'b1;
            n.st = tlbt_pkg::ST_CMP;
         end
         tlbt_pkg::ST_CMP: begin
            n.data[tlbt_pkg::DATA_HIT] = one_hit;
            if (one_hit) begin
               n.data[tlbt_pkg::DATA_PA_LO +: PW] = hit_entry.pa;
               n.data[tlbt_pkg::DATA_CHOICE_LO +: WW] = hit_way;
               n.cmd[tlbt_pkg::CMD_VALID] = 1'b1;
               n.cmd[tlbt_pkg::CMD_DIRTY] = hit_entry.dirty;
               n.cmd[tlbt_pkg::CMD_DIRTY_N] = !hit_entry.dirty;
               n.cmd[tlbt_pkg::CMD_USER] = hit_entry.user;
               n.cmd[tlbt_pkg::CMD_USER_N] = !hit_entry.user;
               n.cmd[tlbt_pkg::CMD_WRT] = hit_entry.wrt;
               n.cmd[tlbt_pkg::CMD_WRT_N] = !hit_entry.wrt;
            end
            n.st = tlbt_pkg::ST_IDLE;
         end
         default: begin
            n.st = tlbt_pkg::ST_IDLE;
         end
      endcase
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r.cmd <= tlbt_pkg::CMD_RESET;
         r.data <= tlbt_pkg::DATA_RESET;
         r.pdb <= tlbt_pkg::PDB_RESET;
         r.repl <= '0;
         r.st <= tlbt_pkg::ST_IDLE;
         r.pready <= 1'b0;
         r.pslverr <= 1'b0;
         r.prdata <= '0;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   a_cmd_write_op: assert property (
      @(posedge clock) disable iff (rst)
      (done && pwrite && sel_cmd && !pwdata[tlbt_pkg::CMD_OP])
         |=> r.st == tlbt_pkg::ST_WRITE ##1 r.st == tlbt_pkg::ST_IDLE)
      else $error("entry write did not follow command write");

   a_cmd_lookup_op: assert property (
      @(posedge clock) disable iff (rst)
      (done && pwrite && sel_cmd && pwdata[tlbt_pkg::CMD_OP])
         |=> mem_rd ##1 r.st == tlbt_pkg::ST_CMP)
      else $error("lookup did not follow command write");

   a_entry_fields: assert property (
      @(posedge clock) disable iff (rst)
      r.st == tlbt_pkg::ST_WRITE
         |-> mem_wr && mem_entry.tag == cmd_tag && mem_entry.pa == data_pa)
      else $error("entry written with wrong tag or address");

   a_hit_loads_pa: assert property (
      @(posedge clock) disable iff (rst)
      (r.st == tlbt_pkg::ST_CMP && one_hit)
         |=> data_pa == $past(hit_entry.pa)
             && data_choice == $past(hit_way))
      else $error("hit did not load entry into data register");

   a_pick_block: assert property (
      @(posedge clock) disable iff (rst)
      (r.st == tlbt_pkg::ST_WRITE && !data_hit)
         |-> mem_way == r.repl ##1 r.repl == $past(r.repl) + WW'(1))
      else $error("replacement pointer not used or not advanced");

   a_chosen_block: assert property (
      @(posedge clock) disable iff (rst)
      (r.st == tlbt_pkg::ST_WRITE && data_hit) |-> mem_way == data_choice)
      else $error("block choice ignored on pick write");

   a_hit_flag: assert property (
      @(posedge clock) disable iff (rst)
      r.st == tlbt_pkg::ST_CMP |=> data_hit == $past(one_hit))
      else $error("hit bit does not report lookup result");

   a_multi_miss: assert property (
      @(posedge clock) disable iff (rst)
      (r.st == tlbt_pkg::ST_CMP && hits != '0 && !$onehot(hits))
         |=> !data_hit)
      else $error("multiple matches reported as hit");

   a_base_flush: assert property (
      @(posedge clock) disable iff (rst)
      (done && pwrite && sel_pdb) |-> mem_flush)
      else $error("directory base write did not flush");

   a_attr_store: assert property (
      @(posedge clock) disable iff (rst)
      (r.st == tlbt_pkg::ST_WRITE && dirty_pair == 2'b01) |-> !mem_entry.dirty)
      else $error("pair 01 did not store zero");

   a_ready_idle: assert property (
      @(posedge clock) disable iff (rst)
      $rose(r.pready) |-> $past(r.st) == tlbt_pkg::ST_IDLE)
      else $error("answered while engine busy");

endmodule

// *** dv/tlbt_top_test.sv ***
// Self-checking bench of the translation buffer test port
`timescale 1ns/100ps
module tlbt_top_test;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic clock;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic err;

   typedef struct {
      logic wr;
      logic [19:0] la;
      logic [2:0] attr;
      logic [19:0] pa;
      logic [1:0] way;
      logic [5:0] look;
      logic hit;
   } tlbt_row_t;

   // Write flag, address, attributes, frame, block, lookup pairs, hit
   tlbt_row_t rows [9] = '{
      '{1'h1, 20'h12343, 3'h5, 20'hABCDE, 2'h0, 6'h3F, 1'h1},
      '{1'h1, 20'h56783, 3'h2, 20'h13579, 2'h1, 6'h19, 1'h1},
      '{1'h1, 20'h9ABC3, 3'h7, 20'hFEDCB, 2'h2, 6'h2A, 1'h1},
      '{1'h1, 20'hDEF03, 3'h0, 20'h02468, 2'h3, 6'h15, 1'h1},
      '{1'h0, 20'h12343, 3'h5, 20'hABCDE, 2'h0, 6'h1F, 1'h0},
      '{1'h0, 20'h12343, 3'h5, 20'hABCDE, 2'h0, 6'h0F, 1'h0},
      '{1'h0, 20'h77777, 3'h0, 20'h00000, 2'h0, 6'h3F, 1'h0},
      '{1'h0, 20'h56783, 3'h2, 20'h13579, 2'h1, 6'h3C, 1'h0},
      '{1'h0, 20'h9ABC3, 3'h7, 20'hFEDCB, 2'h2, 6'h3E, 1'h1}
   };

   tlbt_top u_dut (
      .clock(clock),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr)
   );

   initial begin
      clock = 1'h0;
      forever #2 clock = ~clock;
   end

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [5:0] pairs_of(input logic [2:0] a);
      return {a[2], ~a[2], a[1], ~a[1], a[0], ~a[0]};
   endfunction

   function automatic logic [31:0] cmd_of(input logic [19:0] la,
         input logic [5:0] pr, input logic op);
      return {la, 1'h1, pr, 4'h0, op};
   endfunction

   function automatic logic [31:0] data_of(input logic [19:0] pa,
         input logic pick, input logic [1:0] way);
      return {pa, 7'h00, pick, way, 2'h0};
   endfunction

   task automatic end_sim();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [31:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clock);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do begin
         @(posedge clock);
      end while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // Valid bit written clear, so a hit must set it
   task automatic lookup(input logic [19:0] la, input logic [5:0] pr);
      apb(1'h1, tlbt_pkg::OFF_CMD, cmd_of(la, pr, 1'h1) & 32'hFFFF_F7FF,
         rd, err);
      apb(1'h0, tlbt_pkg::OFF_DATA, 32'h0000_0000, rd, err);
   endtask

   task automatic put(input logic [19:0] la, input logic [2:0] at,
         input logic [19:0] pa, input logic pick, input logic [1:0] way);
      apb(1'h1, tlbt_pkg::OFF_DATA, data_of(pa, pick, way), rd, err);
      apb(1'h1, tlbt_pkg::OFF_CMD, cmd_of(la, pairs_of(at), 1'h0), rd,
         err);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         end_sim();
      end
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      rst = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      repeat (12) @(posedge clock);
      rst <= 1'h0;
      @(posedge clock);
      apb(1'h0, tlbt_pkg::OFF_CMD, 32'h0000_0000, rd, err);
      chk(rd, tlbt_pkg::CMD_RESET);
      apb(1'h0, tlbt_pkg::OFF_DATA, 32'h0000_0000, rd, err);
      chk(rd, tlbt_pkg::DATA_RESET);
      apb(1'h0, tlbt_pkg::OFF_PDB, 32'h0000_0000, rd, err);
      chk(rd, tlbt_pkg::PDB_RESET);
      apb(1'h1, tlbt_pkg::OFF_DATA, 32'hFFFF_FFFF, rd, err);
      apb(1'h0, tlbt_pkg::OFF_DATA, 32'h0000_0000, rd, err);
      chk(rd, tlbt_pkg::DATA_MASK);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            put(rows[i].la, rows[i].attr, rows[i].pa, 1'h1, rows[i].way);
         end
         lookup(rows[i].la, rows[i].look);
         if (rows[i].hit) begin
            chk(rd, data_of(rows[i].pa, 1'h1, rows[i].way));
            apb(1'h0, tlbt_pkg::OFF_CMD, 32'h0000_0000, rd, err);
            chk(rd, cmd_of(rows[i].la, pairs_of(rows[i].attr), 1'h1));
         end else begin
            chk({31'h0, rd[4]}, 32'h0000_0000);
         end
      end
      // Same tag in two blocks
      put(20'h24685, 3'h1, 20'h11111, 1'h1, 2'h0);
      put(20'h24685, 3'h1, 20'h22222, 1'h1, 2'h1);
      lookup(20'h24685, 6'h3F);
      chk({31'h0, rd[4]}, 32'h0000_0000);
      // Directory base write empties the buffer
      apb(1'h1, tlbt_pkg::OFF_PDB, 32'hCAFE_F000, rd, err);
      apb(1'h0, tlbt_pkg::OFF_PDB, 32'h0000_0000, rd, err);
      chk(rd, 32'hCAFE_F000);
      lookup(20'h12343, 6'h3F);
      chk({31'h0, rd[4]}, 32'h0000_0000);
      // Internal pointer picks blocks 0 then 1
      for (int j = 0; j < 2; j++) begin
         put(j ? 20'h22220 : 20'h11110, 3'h6, 20'h0ACE0, 1'h0, 2'h3);
         lookup(j ? 20'h22220 : 20'h11110, 6'h3F);
         chk(rd, data_of(20'h0ACE0, 1'h1, j[1:0]));
      end
      // Unmapped address
      apb(1'h1, 32'h0000_000C, 32'h1234_5678, rd, err);
      chk({31'h0, err}, 32'h0000_0001);
      apb(1'h0, 32'h0000_000C, 32'h0000_0000, rd, err);
      chk(rd, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001);
      // Second reset in mid-run
      @(posedge clock);
      rst <= 1'h1;
      repeat (2) @(posedge clock);
      rst <= 1'h0;
      @(posedge clock);
      apb(1'h0, tlbt_pkg::OFF_PDB, 32'h0000_0000, rd, err);
      chk(rd, tlbt_pkg::PDB_RESET);
      lookup(20'h11110, 6'h3F);
      chk({31'h0, rd[4]}, 32'h0000_0000);
      end_sim();
   end
endmodule
